// *** design/flic_pkg.sv ***
package flic_pkg;
    // =====================================================================
    // Sources, in polling order (index 0 wins a tie within a level).
    localparam int NSRC = 10;
    localparam int SRC_EXT0   = 0;
    localparam int SRC_TMR0   = 1;
    localparam int SRC_EXT1   = 2;
    localparam int SRC_TMR1   = 3;
    localparam int SRC_CAPT   = 4;
    localparam int SRC_SER    = 5;
    localparam int SRC_TMR2   = 6;
    localparam int SRC_CAN    = 7;
    localparam int SRC_CONV   = 8;
    localparam int SRC_CANTMR = 9;

    // =====================================================================
    // Vector addresses, indexed by polling position.
    localparam logic [15:0] VEC_EXT0   = 16'h0003;
    localparam logic [15:0] VEC_TMR0   = 16'h000B;
    localparam logic [15:0] VEC_EXT1   = 16'h0013;
    localparam logic [15:0] VEC_TMR1   = 16'h001B;
    localparam logic [15:0] VEC_CAPT   = 16'h0033;
    localparam logic [15:0] VEC_SER    = 16'h0023;
    localparam logic [15:0] VEC_TMR2   = 16'h002B;
    localparam logic [15:0] VEC_CAN    = 16'h003B;
    localparam logic [15:0] VEC_CONV   = 16'h0043;
    localparam logic [15:0] VEC_CANTMR = 16'h004B;

    // =====================================================================
    // Register byte addresses on the Wishbone bus.
    localparam logic [7:0] ADR_ENABLE_FIRST  = 8'hA8;
    localparam logic [7:0] ADR_ENABLE_SECOND = 8'hE8;
    localparam logic [7:0] ADR_PRIO_LOW      = 8'hB8;
    localparam logic [7:0] ADR_PRIO_HIGH     = 8'hB4;
    localparam logic [7:0] ADR_STATUS        = 8'hC0;
    localparam logic [7:0] ADR_MASK          = 8'hC4;
    localparam logic [7:0] ADR_ACTIVE        = 8'hC8;

    // =====================================================================
    // Field positions and reset values.
    localparam int GLOBAL_EN_BIT = 7;
    localparam logic [7:0] ENABLE_FIRST_RST  = 8'h00;
    localparam logic [2:0] ENABLE_SECOND_RST = 3'h0;
    localparam logic [9:0] PRIO_RST          = 10'h000;
    localparam logic [1:0] STAT_RST          = 2'h0;
    localparam int STAT_TAKEN_BIT = 0;
    localparam int STAT_RETURN_BIT = 1;
endpackage : flic_pkg

// *** design/flic_level_pick.sv ***
`timescale 1ns/100ps
// =========================================================================
// Picks the lowest-index request among those at one priority level.
module flic_level_pick
    import flic_pkg::*;
(
    input  wire logic [NSRC-1:0] req_i,
    input  wire logic [1:0]      lvl_i [NSRC],
    input  wire logic [1:0]      want_i,
    output logic                 hit_o,
    output logic [3:0]           idx_o
);
    // Scan from the back so the earliest polling slot wins.
    always_comb begin
        hit_o = 1'b0;
        idx_o = 4'h0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (req_i[i] && lvl_i[i] == want_i) begin
                hit_o = 1'b1;
                idx_o = 4'(i);
            end
        end
    end
endmodule : flic_level_pick

// *** design/flic_top.sv ***
`timescale 1ns/100ps
module flic_top
    import flic_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        ext_request_pin0_i,
    input  wire logic        ext_request_pin1_i,
    input  wire logic        timer0_overflow_flag_i,
    input  wire logic        timer1_overflow_flag_i,
    input  wire logic        timer2_overflow_flag_i,
    input  wire logic        serial_receive_flag_i,
    input  wire logic        serial_transmit_flag_i,
    input  wire logic        capture_counter_overflow_flag_i,
    input  wire logic [1:0]  capture_module_flag_i,
    input  wire logic        can_transmit_done_i,
    input  wire logic        can_receive_done_i,
    input  wire logic        can_error_i,
    input  wire logic        can_buffer_overrun_i,
    input  wire logic        converter_request_i,
    input  wire logic        can_timer_overflow_i,
    input  wire logic        irq_taken_i,
    input  wire logic        irq_return_i,
    output logic             irq_req_o,
    output logic      [15:0] irq_vector_o,
    output logic             irq_o
);
    // =====================================================================
    // State.
    typedef struct packed {
        logic [7:0]  en_first;
        logic [2:0]  en_second;
        logic [9:0]  prio_low;
        logic [9:0]  prio_high;
        logic [3:0]  active;
        logic [1:0]  stat;
        logic [1:0]  mask;
        logic [1:0]  ext0_sync;
        logic [1:0]  ext1_sync;
        logic        req;
        logic [15:0] vector;
        logic [3:0]  vec_idx;
        logic [1:0]  vec_lvl;
        logic        ack;
        logic [31:0] rdata;
    } flic_state_t;

    flic_state_t st;
    flic_state_t next_st;

    logic [NSRC-1:0] raw_req;
    logic [NSRC-1:0] en_vec;
    logic [NSRC-1:0] live;
    logic [1:0]      lvl [NSRC];
    logic [3:0]      hit;
    logic [3:0]      pick [4];
    logic            win_ok;
    logic [3:0]      win_idx;
    logic [1:0]      win_lvl;
    logic [2:0]      cur_top;
    logic            in_service;
    logic            bus_req;
    logic [7:0]      rd_byte;

    localparam logic [15:0] VEC_TAB [NSRC] = '{VEC_EXT0, VEC_TMR0,
        VEC_EXT1, VEC_TMR1, VEC_CAPT, VEC_SER, VEC_TMR2, VEC_CAN,
        VEC_CONV, VEC_CANTMR};

    // =====================================================================
    // Request gathering; external pins are low-active and synchronised.
    always_comb begin
        raw_req = '0;
        raw_req[SRC_EXT0]   = ~st.ext0_sync[1];
        raw_req[SRC_TMR0]   = timer0_overflow_flag_i;
        raw_req[SRC_EXT1]   = ~st.ext1_sync[1];
        raw_req[SRC_TMR1]   = timer1_overflow_flag_i;
        raw_req[SRC_CAPT]   = capture_counter_overflow_flag_i
                            | (|capture_module_flag_i);
        raw_req[SRC_SER]    = serial_receive_flag_i
                            | serial_transmit_flag_i;
        raw_req[SRC_TMR2]   = timer2_overflow_flag_i;
        raw_req[SRC_CAN]    = can_transmit_done_i | can_receive_done_i
                            | can_error_i | can_buffer_overrun_i;
        raw_req[SRC_CONV]   = converter_request_i;
        raw_req[SRC_CANTMR] = can_timer_overflow_i;
    end

    // Enable bits map onto polling positions; capture sits at bit 6.
    always_comb begin
        en_vec = '0;
        en_vec[SRC_EXT0]   = st.en_first[0];
        en_vec[SRC_TMR0]   = st.en_first[1];
        en_vec[SRC_EXT1]   = st.en_first[2];
        en_vec[SRC_TMR1]   = st.en_first[3];
        en_vec[SRC_SER]    = st.en_first[4];
        en_vec[SRC_TMR2]   = st.en_first[5];
        en_vec[SRC_CAPT]   = st.en_first[6];
        en_vec[SRC_CAN]    = st.en_second[0];
        en_vec[SRC_CONV]   = st.en_second[1];
        en_vec[SRC_CANTMR] = st.en_second[2];
        live = raw_req & en_vec
             & {NSRC{st.en_first[GLOBAL_EN_BIT]}};
    end

    // Priority level per source from its high and low bits.
    always_comb begin
        for (int i = 0; i < NSRC; i++) begin
            lvl[i] = {st.prio_high[i], st.prio_low[i]};
        end
    end

    // =====================================================================
    // One picker per level keeps the polling scan out of the main logic.
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_lvl
            flic_level_pick u_pick (
                .req_i  (live),
                .lvl_i  (lvl),
                .want_i (2'(g)),
                .hit_o  (hit[g]),
                .idx_o  (pick[g])
            );
        end
    endgenerate

    // Highest populated level wins; the in-service stack gates it.
    always_comb begin
        win_ok  = 1'b0;
        win_idx = 4'h0;
        win_lvl = 2'h0;
        for (int l = 0; l < 4; l++) begin
            if (hit[l]) begin
                win_ok  = 1'b1;
                win_idx = pick[l];
                win_lvl = 2'(l);
            end
        end
        cur_top = 3'h0;
        for (int l = 0; l < 4; l++) begin
            if (st.active[l]) begin
                cur_top = 3'(l + 1);
            end
        end
        in_service = |st.active;
        if (in_service && {1'b0, win_lvl} < cur_top) begin
            win_ok = 1'b0;
        end
    end

    // =====================================================================
    // Wishbone read mux; unmapped addresses read zero and still ack.
    assign bus_req = wb_cyc_i & wb_stb_i & ~st.ack;

    always_comb begin
        rd_byte = 8'h00;
        if (wb_adr_i == ADR_ENABLE_FIRST) begin
            rd_byte = st.en_first;
        end else if (wb_adr_i == ADR_ENABLE_SECOND) begin
            rd_byte = {5'h00, st.en_second};
        end else if (wb_adr_i == ADR_PRIO_LOW) begin
            rd_byte = st.prio_low[7:0];
        end else if (wb_adr_i == ADR_PRIO_HIGH) begin
            rd_byte = st.prio_high[7:0];
        end else if (wb_adr_i == ADR_STATUS) begin
            rd_byte = {6'h00, st.stat};
        end else if (wb_adr_i == ADR_MASK) begin
            rd_byte = {6'h00, st.mask};
        end else if (wb_adr_i == ADR_ACTIVE) begin
            rd_byte = {2'h0, st.prio_high[9:8], st.active};
        end
    end

    // =====================================================================
    // Next state.
    always_comb begin
        next_st = st;
        next_st.ext0_sync = {st.ext0_sync[0], ext_request_pin0_i};
        next_st.ext1_sync = {st.ext1_sync[0], ext_request_pin1_i};
        next_st.ack   = bus_req;
        next_st.rdata = bus_req ? {24'h000000, rd_byte} : 32'h00000000;

        // Register writes through byte lane 0.
        if (bus_req && wb_we_i && wb_sel_i[0]) begin
            if (wb_adr_i == ADR_ENABLE_FIRST) begin
                next_st.en_first = wb_dat_i[7:0];
            end else if (wb_adr_i == ADR_ENABLE_SECOND) begin
                next_st.en_second = wb_dat_i[2:0];
            end else if (wb_adr_i == ADR_PRIO_LOW) begin
                next_st.prio_low[7:0] = wb_dat_i[7:0];
            end else if (wb_adr_i == ADR_PRIO_HIGH) begin
                next_st.prio_high[7:0] = wb_dat_i[7:0];
            end else if (wb_adr_i == ADR_STATUS) begin
                next_st.stat = st.stat & ~wb_dat_i[1:0];
            end else if (wb_adr_i == ADR_MASK) begin
                next_st.mask = wb_dat_i[1:0];
            end else if (wb_adr_i == ADR_ACTIVE) begin
                next_st.prio_low[9:8]  = wb_dat_i[1:0];
                next_st.prio_high[9:8] = wb_dat_i[5:4];
            end
        end

        // Vector is registered; request follows the live winner.
        next_st.req = win_ok;
        if (win_ok) begin
            next_st.vector  = VEC_TAB[win_idx];
            next_st.vec_idx = win_idx;
            next_st.vec_lvl = win_lvl;
        end

        // Return pops the top level; a take pushes the offered level.
        if (irq_return_i && in_service) begin
            next_st.active[cur_top[1:0] - 2'h1] = 1'b0;
        end
        if (irq_taken_i && st.req) begin
            next_st.active[st.vec_lvl] = 1'b1;
            next_st.req = 1'b0;
        end

        // Event status; a new event wins over a same-cycle clear.
        if (irq_taken_i && st.req) begin
            next_st.stat[STAT_TAKEN_BIT] = 1'b1;
        end
        if (irq_return_i && in_service) begin
            next_st.stat[STAT_RETURN_BIT] = 1'b1;
        end

        if (rst_i) begin
            next_st = '0;
            next_st.en_first  = ENABLE_FIRST_RST;
            next_st.en_second = ENABLE_SECOND_RST;
            next_st.prio_low  = PRIO_RST;
            next_st.prio_high = PRIO_RST;
            next_st.stat      = STAT_RST;
            next_st.ext0_sync = 2'h3;
            next_st.ext1_sync = 2'h3;
        end
    end

    always_ff @(posedge clk_i) begin
        st <= next_st;
    end

    // =====================================================================
    // Outputs.
    assign wb_ack_o     = st.ack;
    assign wb_dat_o     = st.rdata;
    assign irq_req_o    = st.req;
    assign irq_vector_o = st.vector;
    assign irq_o        = |(st.stat & st.mask);

    // =====================================================================
    // Checks.
    AST_GLOBAL_OFF: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !st.en_first[GLOBAL_EN_BIT] |=> !irq_req_o)
        else $error("Request raised with global enable clear.");
    // The request is registered, so its enable is judged where it was won.
    AST_ENABLE_GATE: assert property (
        @(posedge clk_i) disable iff (rst_i)
        irq_req_o |-> $past(en_vec[win_idx]))
        else $error("Disabled source forwarded.");
    AST_NO_PREEMPT_TOP: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (st.active[3] && !irq_return_i) |=> !irq_req_o)
        else $error("Level 3 service preempted.");
    AST_STRICT_HIGHER: assert property (
        @(posedge clk_i) disable iff (rst_i)
        irq_req_o && $past(in_service) |->
        {1'b0, st.vec_lvl} >= $past(cur_top))
        else $error("Preemption by equal or lower level.");
    AST_HIGHEST_LEVEL: assert property (
        @(posedge clk_i) disable iff (rst_i)
        irq_req_o |-> ($past(hit) >> (st.vec_lvl + 3'd1)) == 4'h0)
        else $error("Higher pending level skipped.");
    AST_VECTOR_MAP: assert property (
        @(posedge clk_i) disable iff (rst_i)
        irq_req_o |-> irq_vector_o == VEC_TAB[st.vec_idx])
        else $error("Vector does not match source.");
    AST_PUSH_LEVEL: assert property (
        @(posedge clk_i) disable iff (rst_i)
        irq_taken_i && irq_req_o |=> st.active[$past(st.vec_lvl)])
        else $error("Taken level not marked in service.");
    // Judged one edge after a reset edge, so no history is needed.
    AST_RESET_ENABLE: assert property (
        @(posedge clk_i)
        rst_i |=> st.en_first == 8'h00)
        else $error("First enable register not cleared by reset.");
    AST_CAN_OR: assert property (
        @(posedge clk_i) disable iff (rst_i)
        raw_req[SRC_CAN] == (can_error_i | can_buffer_overrun_i
        | can_transmit_done_i | can_receive_done_i))
        else $error("CAN request not the OR of its flags.");
endmodule : flic_top

// *** bench/flic_core_model.sv ***
`timescale 1ns/100ps
// =====================================================================
// Core model: takes an offered vector after a chosen number of cycles.
module flic_core_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        req_i,
    input  wire logic [15:0] vector_i,
    input  wire logic        take_en_i,
    input  wire logic [3:0]  delay_i,
    input  wire logic        ret_cmd_i,
    output logic             taken_o,
    output logic             return_o,
    output logic      [15:0] last_vec_o
);
    logic [3:0] wait_cnt;

    // A slow core lets the offer stand, so the bench can watch it first.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            taken_o    <= 1'b0;
            return_o   <= 1'b0;
            last_vec_o <= 16'h0000;
            wait_cnt   <= 4'h0;
        end else begin
            return_o <= ret_cmd_i;
            taken_o  <= 1'b0;
            wait_cnt <= 4'h0;
            if (req_i && take_en_i && !taken_o) begin
                wait_cnt <= wait_cnt + 4'h1;
                if (wait_cnt >= delay_i) begin
                    taken_o    <= 1'b1;
                    wait_cnt   <= 4'h0;
                end
            end
            // The vector counts at the edge where the controller sees taken.
            if (taken_o && req_i) begin
                last_vec_o <= vector_i;
            end
        end
    end
endmodule : flic_core_model

// *** bench/flic_top_tb.sv ***
`timescale 1ns/100ps
// =====================================================================
// Bench for the controller: bus tasks, one task per scenario.
module flic_top_tb;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] wdat = 32'h0, rdat;
    logic        ack, req, irq, taken, ret, ret_cmd = 1'b0;
    logic        take_en = 1'b0;
    logic [3:0]  delay = 4'h2;
    logic [15:0] vec, last_vec;
    logic [9:0]  fl = 10'h000, pl = 10'h000, ph = 10'h000;
    logic [1:0]  alt = 2'h0;
    int          err_count = 0, checks_done = 0;
    logic [15:0] vecs [10] = '{16'h0003, 16'h000B, 16'h0013, 16'h001B,
        16'h0033, 16'h0023, 16'h002B, 16'h003B, 16'h0043, 16'h004B};

    always #2.5 clk_i = ~clk_i;

    // Combined sources pick one of their flags by alt; pins are active low.
    flic_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .ext_request_pin0_i(~fl[0]), .ext_request_pin1_i(~fl[2]),
        .timer0_overflow_flag_i(fl[1]), .timer1_overflow_flag_i(fl[3]),
        .timer2_overflow_flag_i(fl[6]),
        .serial_receive_flag_i(fl[5] && !alt[0]),
        .serial_transmit_flag_i(fl[5] && alt[0]),
        .capture_counter_overflow_flag_i(fl[4] && alt == 2'h0),
        .capture_module_flag_i({fl[4] && alt[1], fl[4] && alt == 2'h1}),
        .can_transmit_done_i(fl[7] && alt == 2'h0),
        .can_receive_done_i(fl[7] && alt == 2'h1),
        .can_error_i(fl[7] && alt == 2'h2),
        .can_buffer_overrun_i(fl[7] && alt == 2'h3),
        .converter_request_i(fl[8]), .can_timer_overflow_i(fl[9]),
        .irq_taken_i(taken), .irq_return_i(ret), .irq_req_o(req),
        .irq_vector_o(vec), .irq_o(irq));

    flic_core_model core (.clk_i(clk_i), .rst_i(rst_i), .req_i(req),
        .vector_i(vec), .take_en_i(take_en), .delay_i(delay),
        .ret_cmd_i(ret_cmd), .taken_o(taken), .return_o(ret),
        .last_vec_o(last_vec));

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Classic cycle; ack and read data are taken at the same rising edge.
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [7:0] d, output logic [7:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= {24'h0, d};
        sel  <= 4'h1;
        @(posedge clk_i);
        while (ack !== 1'b1 && n < 20) begin
            @(posedge clk_i);
            n++;
        end
        if (ack !== 1'b1) err_count++;
        q = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        bus(1'b0, a, 8'h00, q);
    endtask : rd

    task automatic idle(input int n);
        repeat (n) @(posedge clk_i);
    endtask : idle

    task automatic setfl(input logic [9:0] v);
        @(posedge clk_i);
        fl <= v;
    endtask : setfl

    task automatic en(input logic [9:0] m, input logic g);
        wr(8'hA8, {g, m[4], m[6], m[5], m[3:0]});
        wr(8'hE8, {5'h00, m[9:7]});
    endtask : en

    task automatic wr_prio;
        wr(8'hB8, pl[7:0]);
        wr(8'hB4, ph[7:0]);
        wr(8'hC8, {2'b00, ph[9:8], 2'b00, pl[9:8]});
    endtask : wr_prio

    // Expects the given vector offered within 8 cycles; zero means none.
    task automatic offer(input logic [15:0] exp);
        int   n;
        logic seen;
        n = 0;
        seen = 1'b0;
        while (!seen && n < 8) begin
            @(negedge clk_i);
            seen = (req === 1'b1);
            n++;
        end
        check("offer", seen ? {16'h0, vec} : 32'h0, {16'h0, exp});
    endtask : offer

    task automatic t_reset;
        logic [7:0] q;
        rd(8'hA8, q);
        check("enable_first", q, 8'h00);
        rd(8'hE8, q);
        check("enable_second", q, 8'h00);
        wr(8'hA8, 8'hA5);
        rd(8'hA8, q);
        check("enable_rw", q, 8'hA5);
        wr(8'h10, 8'h55);
        rd(8'h10, q);
        check("unmapped", q, 8'h00);
    endtask : t_reset

    // Every source and every flag of the combined ones, gated both ways.
    task automatic t_sources;
        for (int i = 0; i < 10; i++) begin
            for (int a = 0; a < 4; a++) begin
                if (a == 0 || i == 4 || i == 5 || i == 7) begin
                    @(posedge clk_i);
                    alt <= a[1:0];
                    fl  <= 10'h1 << i;
                    en(10'h3FF, 1'b0);
                    offer(16'h0000);
                    en(~(10'h1 << i), 1'b1);
                    offer(16'h0000);
                    en(10'h1 << i, 1'b1);
                    offer(vecs[i]);
                    setfl(10'h000);
                    idle(8);
                end
            end
        end
    endtask : t_sources

    // Requests are armed with the global bit off so they meet at once.
    task automatic t_ties;
        for (int i = 0; i < 9; i++) begin
            en(10'h3FF, 1'b0);
            setfl(10'h3 << i);
            idle(4);
            en(10'h3FF, 1'b1);
            offer(vecs[i]);
            setfl(10'h000);
            idle(8);
        end
    endtask : t_ties

    task automatic t_levels;
        int a, b;
        for (int l = 1; l < 4; l++) begin
            for (int s = 0; s < 2; s++) begin
                a = s ? 9 : 5;
                b = s ? 5 : 9;
                pl = 10'h000;
                ph = 10'h000;
                {ph[a], pl[a]} = l[1:0];
                {ph[b], pl[b]} = l[1:0] - 2'h1;
                wr_prio();
                en(10'h3FF, 1'b0);
                setfl(10'h220);
                idle(4);
                en(10'h3FF, 1'b1);
                offer(vecs[a]);
                setfl(10'h000);
                idle(8);
            end
        end
    endtask : t_levels

    task automatic t_nest;
        logic [7:0] q;
        pl = 10'h207;
        ph = 10'h284;
        wr_prio();
        en(10'h3FF, 1'b1);
        take_en <= 1'b1;
        setfl(10'h002);
        offer(16'h000B);
        idle(6);
        check("taken", {16'h0, last_vec}, 32'h000B);
        setfl(10'h003);
        offer(16'h0000);
        setfl(10'h083);
        offer(16'h003B);
        idle(6);
        setfl(10'h283);
        offer(16'h004B);
        idle(6);
        setfl(10'h287);
        offer(16'h0000);
        rd(8'hC8, q);
        check("active", q, 8'h2E);
        take_en <= 1'b0;
        @(posedge clk_i);
        ret_cmd <= 1'b1;
        @(posedge clk_i);
        ret_cmd <= 1'b0;
        offer(16'h0013);
        setfl(10'h000);
        idle(8);
    endtask : t_nest

    // Status holds taken and return events; mask gates the level output.
    task automatic t_irq;
        logic [7:0] ta [5] = '{8'hC4, 8'hC4, 8'hC0, 8'hC4, 8'hC0};
        logic [7:0] td [5] = '{8'h00, 8'h01, 8'h01, 8'h03, 8'h02};
        logic       te [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
        logic [7:0] q;
        for (int k = 0; k < 5; k++) begin
            wr(ta[k], td[k]);
            idle(2);
            @(negedge clk_i);
            check("irq", {31'h0, irq}, {31'h0, te[k]});
        end
        rd(8'hC0, q);
        check("status", q, 8'h00);
    endtask : t_irq

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : wrap_up

    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_sources();
        t_ties();
        t_levels();
        t_nest();
        t_irq();
        wrap_up();
    end

    // The whole run needs under two thousand cycles; this bounds a hang.
    initial begin
        repeat (20000) @(posedge clk_i);
        err_count++;
        wrap_up();
    end
endmodule : flic_top_tb
